// [supply_monitor.sv]
// Digital control and flag logic of the supply monitor, with AXI4-Lite registers.
// Assumes the analogue comparator output arrives asynchronously on COMPARE_LOW.
`timescale 1ns/1ps
module supply_monitor (
  input wire logic MCLK,
  input wire logic RESET,
  input wire logic COMPARE_LOW,
  input wire logic POWERED_DOWN,
  input wire logic [31:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [31:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  output logic MONITOR_POWER_ON,
  output logic [2:0] THRESHOLD_SELECT,
  output logic MULTI_FUNCTION_IRQ,
  output logic WAKE_UP
);

  // ****************************************************************
  // Control state
  // ****************************************************************
  supply_monitor_pkg::control_type control_reg;  // Threshold and enable
  logic flag_reg;         // Low supply interrupt request flag
  logic flag_prev_reg;    // Flag delayed, for edge detection
  logic sync1_reg;        // First synchroniser stage, read by sync2 only
  logic sync2_reg;        // Second synchroniser stage
  logic qualified;        // Low level stood for the full delay
  logic qualified_prev_reg;  // For rising edge of qualification
  logic detect;           // Gated detect level

  // ****************************************************************
  // Bus state
  // ****************************************************************
  logic aw_held_reg;       // Write address taken, waiting for data
  logic w_held_reg;        // Write data taken, waiting for address
  logic [7:0] aw_addr_reg; // Latched write address
  logic [31:0] w_data_reg; // Latched write data
  logic [3:0] w_strb_reg;  // Latched write strobes
  logic do_write;          // Both halves present this cycle
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic flag_set;
  logic flag_write;
  logic flag_wdata;
  supply_monitor_pkg::read_answer_type read_answer;

  // ****************************************************************
  // Comparator synchroniser
  // ****************************************************************
  // Two flops; the analogue output has no relation to MCLK
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
    end else begin
      sync1_reg <= COMPARE_LOW;
      sync2_reg <= sync1_reg;
    end
  end

  // Detect reads low while the detector is switched off; POWERED_DOWN has no say
  assign detect = control_reg.on & sync2_reg;

  // ****************************************************************
  // Qualification delay
  // ****************************************************************
  supply_qualifier #(
    .CYCLES(supply_monitor_pkg::QUALIFY_CYCLES)
  ) qualifier (
    .clk(MCLK),
    .rst(RESET),
    .detect(detect),
    .qualified(qualified)
  );

  // Edge of qualification; chatter only restarts the count
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      qualified_prev_reg <= 1'b0;
    end else begin
      qualified_prev_reg <= qualified;
    end
  end

  assign flag_set = qualified & ~qualified_prev_reg;

  // ****************************************************************
  // Write channel
  // ****************************************************************
  // Address and data are taken in either order and joined here
  assign wr_addr = aw_held_reg ? aw_addr_reg : S_AXI_AWADDR[7:0];
  assign wr_data = w_held_reg ? w_data_reg : S_AXI_WDATA;
  assign wr_strb = w_held_reg ? w_strb_reg : S_AXI_WSTRB;
  assign do_write = (aw_held_reg | (S_AXI_AWVALID & S_AXI_AWREADY)) &
                    (w_held_reg | (S_AXI_WVALID & S_AXI_WREADY));

  // Ready drops while a response waits, which keeps one write in flight
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY <= 1'b0;
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 32'h00000000;
      w_strb_reg <= 4'h0;
    end else if (do_write) begin
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY <= 1'b0;
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
    end else begin
      // Offer ready only when idle
      S_AXI_AWREADY <= ~aw_held_reg & ~S_AXI_BVALID & ~(S_AXI_AWVALID & S_AXI_AWREADY);
      S_AXI_WREADY <= ~w_held_reg & ~S_AXI_BVALID & ~(S_AXI_WVALID & S_AXI_WREADY);
      if (S_AXI_AWVALID & S_AXI_AWREADY) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= S_AXI_AWADDR[7:0];
      end
      if (S_AXI_WVALID & S_AXI_WREADY) begin
        w_held_reg <= 1'b1;
        w_data_reg <= S_AXI_WDATA;
        w_strb_reg <= S_AXI_WSTRB;
      end
    end
  end

  // Response: OKAY for mapped words, SLVERR elsewhere
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= supply_monitor_pkg::RESP_OKAY;
    end else if (do_write) begin
      S_AXI_BVALID <= 1'b1;
      if (wr_addr == supply_monitor_pkg::CONTROL_OFFSET || wr_addr == supply_monitor_pkg::FLAG_OFFSET) begin
        S_AXI_BRESP <= supply_monitor_pkg::RESP_OKAY;
      end else begin
        S_AXI_BRESP <= supply_monitor_pkg::RESP_SLVERR;
      end
    end else if (S_AXI_BREADY) begin
      S_AXI_BVALID <= 1'b0;
    end
  end

  // ****************************************************************
  // Control register
  // ****************************************************************
  // Only byte lane 0 holds fields; other lanes are ignored
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      control_reg.threshold <= supply_monitor_pkg::THRESHOLD_RESET;
      control_reg.on <= supply_monitor_pkg::ENABLE_RESET;
    end else if (do_write && wr_addr == supply_monitor_pkg::CONTROL_OFFSET && wr_strb[0]) begin
      control_reg.threshold <= wr_data[supply_monitor_pkg::THRESHOLD_LSB +: supply_monitor_pkg::THRESHOLD_WIDTH];
      control_reg.on <= wr_data[supply_monitor_pkg::ENABLE_BIT];
    end
  end

  // ****************************************************************
  // Interrupt request flag
  // ****************************************************************
  assign flag_write = do_write && wr_addr == supply_monitor_pkg::FLAG_OFFSET && wr_strb[0];
  assign flag_wdata = wr_data[supply_monitor_pkg::FLAG_BIT];

  // Software may write either value, so it can preset the flag before sleep;
  // a hardware set in the same cycle wins over a clear
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      flag_reg <= 1'b0;
    end else if (flag_set) begin
      flag_reg <= 1'b1;
    end else if (flag_write) begin
      flag_reg <= flag_wdata;
    end
  end

  // Delayed copy for the wake-up edge
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      flag_prev_reg <= 1'b0;
    end else begin
      flag_prev_reg <= flag_reg;
    end
  end

  // ****************************************************************
  // Side outputs
  // ****************************************************************
  // All registered so the outputs come straight from flops
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      MONITOR_POWER_ON <= 1'b0;
      THRESHOLD_SELECT <= supply_monitor_pkg::THRESHOLD_RESET;
      MULTI_FUNCTION_IRQ <= 1'b0;
      WAKE_UP <= 1'b0;
    end else begin
      MONITOR_POWER_ON <= control_reg.on;
      THRESHOLD_SELECT <= control_reg.threshold;
      MULTI_FUNCTION_IRQ <= flag_reg;
      WAKE_UP <= flag_reg & ~flag_prev_reg & POWERED_DOWN;
    end
  end

  // ****************************************************************
  // Read channel
  // ****************************************************************
  // Read data built from live state; reserved bits read zero
  always_comb begin
    read_answer.data = 32'h00000000;
    read_answer.resp = supply_monitor_pkg::RESP_OKAY;
    case (S_AXI_ARADDR[7:0])
      supply_monitor_pkg::CONTROL_OFFSET: begin
        read_answer.data[supply_monitor_pkg::THRESHOLD_LSB +: supply_monitor_pkg::THRESHOLD_WIDTH] =
          control_reg.threshold;
        read_answer.data[supply_monitor_pkg::ENABLE_BIT] = control_reg.on;
        read_answer.data[supply_monitor_pkg::DETECT_BIT] = detect;
      end
      supply_monitor_pkg::FLAG_OFFSET: begin
        read_answer.data[supply_monitor_pkg::FLAG_BIT] = flag_reg;
      end
      default: begin
        read_answer.resp = supply_monitor_pkg::RESP_SLVERR;
      end
    endcase
  end

  // Address taken, answer one cycle later, held until rready
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h00000000;
      S_AXI_RRESP <= supply_monitor_pkg::RESP_OKAY;
    end else if (S_AXI_ARVALID & S_AXI_ARREADY) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID <= 1'b1;
      S_AXI_RDATA <= read_answer.data;
      S_AXI_RRESP <= read_answer.resp;
    end else if (S_AXI_RVALID) begin
      if (S_AXI_RREADY) begin
        S_AXI_RVALID <= 1'b0;
      end
    end else begin
      S_AXI_ARREADY <= 1'b1;
    end
  end

endmodule

// [supply_monitor_pkg.sv]
// Package for the supply monitor control block: register map, field layout,
// reset values, timing figures and the bus carrier structs.
// Assumes a 40 MHz system clock and an AXI4-Lite master with 32-bit data.
package supply_monitor_pkg;

  // ****************************************************************
  // Register map (byte addresses, one aligned word each)
  // ****************************************************************
  localparam logic [7:0] CONTROL_OFFSET = 8'h00;  // Supply monitor control
  localparam logic [7:0] FLAG_OFFSET = 8'h04;     // Interrupt request flag word

  // ****************************************************************
  // Control field positions and reset values
  // ****************************************************************
  localparam int THRESHOLD_LSB = 0;
  localparam int THRESHOLD_WIDTH = 3;
  localparam int ENABLE_BIT = 4;
  localparam int DETECT_BIT = 5;
  localparam int FLAG_BIT = 0;
  localparam logic [2:0] THRESHOLD_RESET = 3'h0;
  localparam logic ENABLE_RESET = 1'b0;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLOCK_HZ = 40000000;
  localparam int QUALIFY_DELAY_NS = 1000;  // Qualification delay, least time
  localparam int QUALIFY_CYCLES =
    ((QUALIFY_DELAY_NS * (CLOCK_HZ / 1000000)) + 999) / 1000 < 1 ? 1 :
    ((QUALIFY_DELAY_NS * (CLOCK_HZ / 1000000)) + 999) / 1000;

  // ****************************************************************
  // AXI4-Lite response codes and carriers
  // ****************************************************************
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [31:0] data;
    logic [1:0] resp;
  } read_answer_type;

  typedef struct packed {
    logic [2:0] threshold;
    logic on;
  } control_type;

endpackage

// [supply_qualifier.sv]
// Qualification delay for the low supply indication.
// Assumes its input is already synchronous to the clock.
`timescale 1ns/1ps
module supply_qualifier #(
  parameter int CYCLES = 40
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic detect,
  output logic qualified
);

  // ****************************************************************
  // Checks
  // ****************************************************************
  initial begin
    if (CYCLES < 1) begin
      $error("CYCLES must be at least one");
    end
  end

  localparam int CW = $clog2(CYCLES + 1);
  logic [CW-1:0] count_reg;  // Cycles the detect level has stood high

  // Counter restarts on every drop so a chattering level never qualifies early
  always_ff @(posedge clk) begin
    if (rst) begin
      count_reg <= '0;
    end else if (!detect) begin
      count_reg <= '0;
    end else if (count_reg != CW'(CYCLES)) begin
      count_reg <= count_reg + CW'(1);
    end
  end

  // Qualified once the full delay has passed
  assign qualified = (count_reg == CW'(CYCLES));

endmodule

// [supply_monitor_chk.sv]
// Checker for the supply monitor: bus answers, field hold, qualification and wake-up.
// Assumes it is bound into the supply monitor and sees only its ports.
`timescale 1ns/1ps
module supply_monitor_chk (
  input wire logic MCLK,
  input wire logic RESET,
  input wire logic COMPARE_LOW,
  input wire logic POWERED_DOWN,
  input wire logic S_AXI_AWVALID,
  input wire logic S_AXI_AWREADY,
  input wire logic S_AXI_WVALID,
  input wire logic S_AXI_WREADY,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic S_AXI_RVALID,
  input wire logic MONITOR_POWER_ON,
  input wire logic [2:0] THRESHOLD_SELECT,
  input wire logic MULTI_FUNCTION_IRQ,
  input wire logic WAKE_UP
);
  // ****************************************************************
  // Run of enabled low-supply cycles
  // ****************************************************************
  int low_run; // Saturates so a long sag cannot wrap it
  always_ff @(posedge MCLK) begin
    if (RESET || !COMPARE_LOW || !MONITOR_POWER_ON) begin
      low_run <= 0;
    end else if (low_run < 1000) begin
      low_run <= low_run + 1;
    end
  end
  default clocking @(posedge MCLK); endclocking
  default disable iff (RESET);
  // ****************************************************************
  // Properties
  // ****************************************************************
  sequence s_write_pair;
    S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
  endsequence
  sequence s_read_take;
    S_AXI_ARVALID && S_AXI_ARREADY;
  endsequence
  property p_write_answer;
    s_write_pair |=> S_AXI_BVALID;
  endproperty
  a_write_answer: assert property (p_write_answer) else $error("write response missing");
  property p_read_answer;
    s_read_take |=> S_AXI_RVALID;
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("read response missing");
  property p_write_done;
    S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID;
  endproperty
  a_write_done: assert property (p_write_done) else $error("write response not withdrawn");
  // Fields only move as the result of a completed write
  property p_field_hold;
    !$stable({MONITOR_POWER_ON, THRESHOLD_SELECT}) |-> S_AXI_BVALID || $past(S_AXI_BVALID);
  endproperty
  a_field_hold: assert property (p_field_hold) else $error("control field moved without write");
  // A hardware raise needs a full qualification run behind it
  property p_qualify;
    $rose(MULTI_FUNCTION_IRQ) && !$past(S_AXI_BVALID) && !$past(S_AXI_BVALID, 2)
      |-> low_run >= supply_monitor_pkg::QUALIFY_CYCLES;
  endproperty
  a_qualify: assert property (p_qualify) else $error("request raised too early");
  property p_wake_gate;
    WAKE_UP |-> $past(POWERED_DOWN) ##[0:1] MULTI_FUNCTION_IRQ;
  endproperty
  a_wake_gate: assert property (p_wake_gate) else $error("wake without sleep or request");
  property p_wake_pulse;
    WAKE_UP |=> !WAKE_UP;
  endproperty
  a_wake_pulse: assert property (p_wake_pulse) else $error("wake pulse too long");
  property p_detect_off;
    $rose(S_AXI_RVALID) && !MONITOR_POWER_ON && !$past(MONITOR_POWER_ON, 2)
      |-> !S_AXI_RDATA[supply_monitor_pkg::DETECT_BIT];
  endproperty
  a_detect_off: assert property (p_detect_off) else $error("detect bit set while off");
  property p_detect_on;
    $rose(S_AXI_RVALID) && S_AXI_RDATA[supply_monitor_pkg::DETECT_BIT]
      |-> MONITOR_POWER_ON && $past(COMPARE_LOW, 3);
  endproperty
  a_detect_on: assert property (p_detect_on) else $error("detect bit without low supply");
endmodule

// [tb.sv]
// Testbench for the supply monitor: register access over AXI4-Lite and comparator stimulus.
// Assumes the package, the design and the checker are compiled before it.
`timescale 1ns/1ps
module tb;
  // ****************************************************************
  // Signals
  // ****************************************************************
  localparam logic [31:0] CTRL = {24'h0, supply_monitor_pkg::CONTROL_OFFSET};
  localparam logic [31:0] FLAG = {24'h0, supply_monitor_pkg::FLAG_OFFSET};
  localparam int QC = supply_monitor_pkg::QUALIFY_CYCLES;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic cmp = 1'b0; // Comparator: high means supply low
  logic pd = 1'b0; // Sleep or idle
  logic [31:0] awa = 32'h0, wd = 32'h0, ara = 32'h0, rdata, got;
  logic [3:0] ws = 4'hf;
  logic awv = 1'b0, wv = 1'b0, arv = 1'b0, awr, wr, bv, arr, rv, pon, irq, wake;
  logic [1:0] bresp, rresp, resp;
  logic [2:0] thr;
  int wake_count = 0; // Wake pulses seen, only this counter's process writes it
  int wake_base; // Count at the start of a scenario
  int n_mismatch = 0;
  int tests_run = 0;
  always #12.5 mclk = ~mclk;
  always @(posedge mclk) if (wake) wake_count <= wake_count + 1;
  // Responses are always accepted at once
  supply_monitor DUT (
    .MCLK(mclk), .RESET(rst), .COMPARE_LOW(cmp), .POWERED_DOWN(pd),
    .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
    .S_AXI_WDATA(wd), .S_AXI_WSTRB(ws), .S_AXI_WVALID(wv), .S_AXI_WREADY(wr),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv), .S_AXI_BREADY(1'b1),
    .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdata),
    .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv), .S_AXI_RREADY(1'b1), .MONITOR_POWER_ON(pon),
    .THRESHOLD_SELECT(thr), .MULTI_FUNCTION_IRQ(irq), .WAKE_UP(wake)
  );
  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic summarize;
    if (n_mismatch == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic check(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // Address and data offered together, each dropped when taken
  task automatic wr_reg(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    bit aw_done, w_done;
    n = 0;
    aw_done = 1'b0;
    w_done = 1'b0;
    awa <= a;
    wd <= d;
    ws <= s;
    awv <= 1'b1;
    wv <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
      if (!aw_done && awr) begin
        aw_done = 1'b1;
        awv <= 1'b0;
      end
      if (!w_done && wr) begin
        w_done = 1'b1;
        wv <= 1'b0;
      end
    end while (!bv && n < 200);
    resp = bresp;
    if (n >= 200) begin
      n_mismatch++;
      summarize();
    end
  endtask
  task automatic rd_reg(input logic [31:0] a);
    int n;
    bit ar_done;
    n = 0;
    ar_done = 1'b0;
    ara <= a;
    arv <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
      if (!ar_done && arr) begin
        ar_done = 1'b1;
        arv <= 1'b0;
      end
    end while (!(rv && ar_done) && n < 200);
    got = rdata;
    resp = rresp;
    if (n >= 200) begin
      n_mismatch++;
      summarize();
    end
  endtask
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    int t;
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    rd_reg(CTRL);
    check(got, 32'h0);
    rd_reg(32'h8);
    check({30'h0, resp}, {30'h0, supply_monitor_pkg::RESP_SLVERR});
    // Unmapped write is refused, a mapped one answers OKAY
    wr_reg(32'h8, 32'h17, 4'hf);
    check({30'h0, resp}, {30'h0, supply_monitor_pkg::RESP_SLVERR});
    wr_reg(CTRL, 32'h0, 4'hf);
    check({30'h0, resp}, {30'h0, supply_monitor_pkg::RESP_OKAY});
    // Every code, with stray bits that must not stick
    for (int i = 0; i < 8; i++) begin
      wr_reg(CTRL, 32'hffffffe8 | i, 4'hf);
      rd_reg(CTRL);
      check(got, i);
      check({29'h0, thr}, i);
    end
    wr_reg(CTRL, 32'h10, 4'he); // Lane 0 not strobed: no effect
    rd_reg(CTRL);
    check(got, 32'h7);
    // Low supply while off: nothing seen
    cmp <= 1'b1;
    repeat (60) @(posedge mclk);
    rd_reg(CTRL);
    check(got, 32'h7);
    check({31'h0, irq}, 32'h0);
    wr_reg(CTRL, 32'h15, 4'hf);
    for (t = 0; irq !== 1'b1 && t < 200; t++) @(posedge mclk);
    check({31'h0, t >= QC && t <= QC + 8}, 32'h1);
    rd_reg(CTRL);
    check(got, 32'h35);
    check({31'h0, pon}, 32'h1);
    // Chatter shorter than the delay never raises the request
    cmp <= 1'b0;
    repeat (10) @(posedge mclk);
    wr_reg(FLAG, 32'h0, 4'hf);
    for (int k = 0; k < 10; k++) begin
      cmp <= ~cmp;
      repeat (20) @(posedge mclk);
    end
    rd_reg(FLAG);
    check(got, 32'h0);
    // Sag while asleep sets the request and wakes
    cmp <= 1'b0;
    pd <= 1'b1;
    wake_base = wake_count;
    repeat (10) @(posedge mclk);
    cmp <= 1'b1;
    repeat (100) @(posedge mclk);
    check({31'h0, irq}, 32'h1);
    check(wake_count - wake_base, 32'h1);
    // Preset flag before sleep suppresses the wake
    pd <= 1'b0;
    cmp <= 1'b0;
    wr_reg(FLAG, 32'h0, 4'hf);
    wr_reg(FLAG, 32'h1, 4'hf);
    wake_base = wake_count;
    pd <= 1'b1;
    cmp <= 1'b1;
    repeat (100) @(posedge mclk);
    check(wake_count - wake_base, 32'h0);
    wr_reg(CTRL, 32'h5, 4'hf);
    repeat (5) @(posedge mclk);
    rd_reg(CTRL);
    check(got, 32'h5);
    check({31'h0, pon}, 32'h0);
    summarize();
  end
endmodule
bind supply_monitor supply_monitor_chk chk (.*);
